// File: inc/dspc_defs.vh
// Constants for the dual serial port: register map, digit codes, timing
// Assumes a 50 MHz system clock and a plain strobe register port
`ifndef DSPC_DEFS_VH
`define DSPC_DEFS_VH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define DSPC_ADDR_W        4
`define DSPC_A_CFG_BI      4'h0
`define DSPC_A_CFG_UNI     4'h1
`define DSPC_A_TX_BI       4'h2
`define DSPC_A_RX_BI       4'h3
`define DSPC_A_TX_UNI      4'h4
`define DSPC_A_STATUS      4'h5

// ----------------------------------------------------------------------
// Configuration digit codes and reset values
// ----------------------------------------------------------------------
`define DSPC_RST_CFG_BI    17'h10021
`define DSPC_RST_CFG_UNI   14'h1008
`define DSPC_BAUD_DEF_BI   4'h8
`define DSPC_BAUD_DEF_UNI  4'h4
`define DSPC_PAR_EVEN      3'h0
`define DSPC_PAR_ODD       3'h1
`define DSPC_PAR_ONE       3'h2
`define DSPC_PAR_ZERO      3'h3
`define DSPC_PAR_NONE      3'h4
`define DSPC_HS_NONE       2'h0
`define DSPC_HS_MODEM      2'h1
`define DSPC_HS_XONOFF     2'h2
`define DSPC_HS_PROG       2'h3
`define DSPC_IF_TTY        1'h0
`define DSPC_IF_RS232      1'h1
`define DSPC_CH_XON        8'h11
`define DSPC_CH_XOFF       8'h13

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define DSPC_CLK_HZ        50000000
`define DSPC_DIV_W         20

`endif

// File: hw/dspc_baud.v
// Baud code to bit-period divider, ticks at bit rate and mid-bit
// Assumes the clock rate in the constants header
`timescale 1ns/1ns
`include "dspc_defs.vh"
module dspc_baud #(
   parameter CLK_HZ = `DSPC_CLK_HZ
) (
   input  wire                    sys_clk_i,
   input  wire                    sys_rst_i,
   input  wire [3:0]              code_i,
   input  wire                    restart_i,
   output wire                    bit_tick_o,
   output wire                    half_tick_o
);
   reg  [31:0]            div_full;
   reg  [`DSPC_DIV_W-1:0] period;
   reg  [`DSPC_DIV_W-1:0] cnt_q;

   // ----------------------------------------------------------------------
   // Divider choice
   // ----------------------------------------------------------------------
   always @* begin
      case (code_i)
         4'h1:    div_full = CLK_HZ / 110;
         4'h2:    div_full = CLK_HZ / 200;
         4'h3:    div_full = CLK_HZ / 300;
         4'h4:    div_full = CLK_HZ / 600;
         4'h5:    div_full = CLK_HZ / 1200;
         4'h6:    div_full = CLK_HZ / 2400;
         4'h7:    div_full = CLK_HZ / 4800;
         default: div_full = CLK_HZ / 9600;
      endcase
      period = div_full[`DSPC_DIV_W-1:0];
   end

   always @(posedge sys_clk_i) begin
      if (sys_rst_i || restart_i || bit_tick_o)
         cnt_q <= {`DSPC_DIV_W{1'b0}};
      else
         cnt_q <= cnt_q + 1'b1;
   end

   assign bit_tick_o  = (cnt_q == period - 1'b1);
   assign half_tick_o = (cnt_q == {1'b0, period[`DSPC_DIV_W-1:1]});
endmodule

// File: hw/dspc_tx.v
// Serial frame transmitter with format and parity selection
// Assumes bit ticks from a divider and a go pulse only while idle
`timescale 1ns/1ns
`include "dspc_defs.vh"
module dspc_tx (
   input  wire                    sys_clk_i,
   input  wire                    sys_rst_i,
   input  wire                    bit_tick_i,
   input  wire [2:0]              fmt_i,
   input  wire [2:0]              par_i,
   input  wire                    go_i,
   input  wire [7:0]              data_i,
   output wire                    busy_o,
   output reg                     txd_o
);
   reg  [3:0]  cnt_q;
   reg  [10:0] sh_q;
   reg         act_q;
   reg         eight;
   reg         haspar;
   reg         two;
   reg         pbit;
   reg  [3:0]  len;
   reg  [10:0] frame;

   // ----------------------------------------------------------------------
   // Frame assembly
   // ----------------------------------------------------------------------
   always @* begin
      eight  = (fmt_i == 3'h1) || (fmt_i == 3'h2) || (fmt_i == 3'h5);
      haspar = (fmt_i == 3'h0) || (fmt_i == 3'h1) || (fmt_i == 3'h4);
      two    = (fmt_i == 3'h0) || (fmt_i == 3'h2) || (fmt_i == 3'h3);
      case (par_i)
         `DSPC_PAR_EVEN: pbit = eight ? ^data_i : ^data_i[6:0];
         `DSPC_PAR_ODD:  pbit = eight ? ~^data_i : ~^data_i[6:0];
         `DSPC_PAR_ONE:  pbit = 1'b1;
         default:        pbit = 1'b0;
      endcase
      len = 4'h9 + {3'h0, eight} + {3'h0, haspar} + {3'h0, two};
      if (eight)
         frame = haspar ? {1'b1, 1'b1, pbit, data_i} : {2'b11, 1'b1, data_i};
      else
         frame = haspar ? {2'b11, 1'b1, pbit, data_i[6:0]}
                        : {2'b11, 2'b11, data_i[6:0]};
   end

   always @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         act_q <= 1'b0;
         cnt_q <= 4'h0;
         sh_q  <= 11'h7FF;
         txd_o <= 1'b1;
      end else if (!act_q) begin
         if (go_i) begin
            act_q <= 1'b1;
            cnt_q <= len;
            sh_q  <= frame;
            txd_o <= 1'b0;
         end
      end else if (bit_tick_i) begin
         if (cnt_q == 4'h1) begin
            act_q <= 1'b0;
            txd_o <= 1'b1;
         end else begin
            txd_o <= sh_q[0];
            sh_q  <= {1'b1, sh_q[10:1]};
         end
         cnt_q <= cnt_q - 1'b1;
      end
   end

   assign busy_o = act_q;
endmodule

// File: hw/dspc_top.v
// Two-channel serial port: bidirectional terminal port and transmit-only port
// Assumes strobe register port; tx go issued only at frame boundaries
`timescale 1ns/1ns
`include "dspc_defs.vh"
module dspc_top (
   input  wire                    sys_clk_i,
   input  wire                    sys_rst_i,
   input  wire [`DSPC_ADDR_W-1:0] addr_i,
   input  wire [31:0]             wdata_i,
   input  wire                    wr_i,
   input  wire                    rd_i,
   output reg  [31:0]             rdata_o,
   output wire                    bi_txd_o,
   input  wire                    bi_rxd_i,
   output wire                    bi_rts_o,
   input  wire                    bi_cts_i,
   output wire                    bi_rs232_sel_o,
   output wire                    uni_txd_o,
   input  wire                    uni_busy_n_i
);
   // ----------------------------------------------------------------------
   // Configuration registers
   // ----------------------------------------------------------------------
   reg  [16:0] cfg_bi_q;
   reg  [13:0] cfg_uni_q;
   reg  [7:0]  txb_q;
   reg         txb_full_q;
   reg  [7:0]  txu_q;
   reg         txu_full_q;
   reg  [7:0]  rx_q;
   reg         rx_full_q;
   reg         rx_ovr_q;
   reg         rx_perr_q;
   reg         xoff_q;
   reg         bad_cfg_q;
   reg  [3:0]  d0, d1, d2, d3, d4;
   reg  [16:0] rem;
   reg  [16:0] quo;

   // Five-digit decimal word split into digits
   always @* begin
      rem = wdata_i[16:0];
      quo = rem / 17'd10000;
      d0  = quo[3:0];
      rem = rem % 17'd10000;
      quo = rem / 17'd1000;
      d1  = quo[3:0];
      rem = rem % 17'd1000;
      quo = rem / 17'd100;
      d2  = quo[3:0];
      rem = rem % 17'd100;
      quo = rem / 17'd10;
      d3  = quo[3:0];
      quo = rem % 17'd10;
      d4  = quo[3:0];
   end

   wire [3:0] bi_baud = cfg_bi_q[16:13];
   wire [2:0] bi_par  = cfg_bi_q[12:10];
   wire [1:0] bi_hs   = cfg_bi_q[9:8];
   wire [2:0] bi_fmt  = cfg_bi_q[7:5];
   wire       bi_if   = cfg_bi_q[0];
   wire [3:0] u_baud  = cfg_uni_q[13:10];
   wire [2:0] u_par   = cfg_uni_q[9:7];
   wire       u_hs    = cfg_uni_q[6];
   wire [2:0] u_fmt   = cfg_uni_q[5:3];

   wire wr_cfg_bi  = wr_i && (addr_i == `DSPC_A_CFG_BI);
   wire wr_cfg_uni = wr_i && (addr_i == `DSPC_A_CFG_UNI);
   wire bi_ok = (d0 >= 4'h1) && (d0 <= 4'h8) && (d1 <= 4'h4) && (d2 <= 4'h3)
                && (d3 <= 4'h5) && (d4 <= 4'h1) && (wdata_i[31:17] == 15'h0)
                && !(d2 == 4'h1 && d4 == 4'h0);
   wire u_ok  = (d1 >= 4'h1) && (d1 <= 4'h7) && (d2 <= 4'h3) && (d3 <= 4'h1)
                && (d4 <= 4'h5) && (d0 == 4'h0) && (wdata_i[31:17] == 15'h0);

   // ----------------------------------------------------------------------
   // Baud generators and transmitters
   // ----------------------------------------------------------------------
   wire bi_tick, bi_half, u_tick;
   wire bi_tx_busy, u_tx_busy, bi_go, u_go;
   reg  rx_act_q;
   wire rx_restart;

   dspc_baud u_bi_tx_baud (
      .sys_clk_i   (sys_clk_i),
      .sys_rst_i   (sys_rst_i),
      .code_i      (bi_baud),
      .restart_i   (wr_cfg_bi || bi_go),
      .bit_tick_o  (bi_tick),
      .half_tick_o ()
   );

   dspc_baud u_bi_rx_baud (
      .sys_clk_i   (sys_clk_i),
      .sys_rst_i   (sys_rst_i),
      .code_i      (bi_baud),
      .restart_i   (rx_restart),
      .bit_tick_o  (),
      .half_tick_o (bi_half)
   );

   dspc_baud u_uni_baud (
      .sys_clk_i   (sys_clk_i),
      .sys_rst_i   (sys_rst_i),
      .code_i      (u_baud),
      .restart_i   (wr_cfg_uni || u_go),
      .bit_tick_o  (u_tick),
      .half_tick_o ()
   );

   wire bi_hold = ((bi_hs == `DSPC_HS_XONOFF) && xoff_q)
                  || ((bi_hs == `DSPC_HS_MODEM) && bi_if && !bi_cts_i);
   assign bi_go = txb_full_q && !bi_tx_busy && !bi_hold;
   wire u_hold = u_hs && !uni_busy_n_i;
   assign u_go = txu_full_q && !u_tx_busy && !u_hold;

   dspc_tx u_bi_tx (
      .sys_clk_i  (sys_clk_i),
      .sys_rst_i  (sys_rst_i),
      .bit_tick_i (bi_tick),
      .fmt_i      (bi_fmt),
      .par_i      (bi_par),
      .go_i       (bi_go),
      .data_i     (txb_q),
      .busy_o     (bi_tx_busy),
      .txd_o      (bi_txd_o)
   );

   dspc_tx u_uni_tx (
      .sys_clk_i  (sys_clk_i),
      .sys_rst_i  (sys_rst_i),
      .bit_tick_i (u_tick),
      .fmt_i      (u_fmt),
      .par_i      (u_par),
      .go_i       (u_go),
      .data_i     (txu_q),
      .busy_o     (u_tx_busy),
      .txd_o      (uni_txd_o)
   );

   // ----------------------------------------------------------------------
   // Receiver state machine
   // ----------------------------------------------------------------------
   localparam RX_IDLE  = 4'b0001;
   localparam RX_START = 4'b0010;
   localparam RX_DATA  = 4'b0100;
   localparam RX_STOP  = 4'b1000;

   reg  [3:0] rx_st_q;
   reg  [3:0] rx_cnt_q;
   reg  [7:0] rx_sh_q;
   reg        rx_pbit_q;
   wire       rx_eight  = (bi_fmt == 3'h1) || (bi_fmt == 3'h2) || (bi_fmt == 3'h5);
   wire       rx_haspar = (bi_fmt == 3'h0) || (bi_fmt == 3'h1) || (bi_fmt == 3'h4);
   wire [3:0] rx_bits   = 4'h7 + {3'h0, rx_eight} + {3'h0, rx_haspar};
   wire [7:0] rx_byte   = rx_eight ? rx_sh_q : {1'b0, rx_sh_q[7:1]};
   reg        rx_exp;
   reg        rx_bad;

   assign rx_restart = ((rx_st_q == RX_IDLE) && !bi_rxd_i) || wr_cfg_bi;
   wire   rd_rx      = rd_i && (addr_i == `DSPC_A_RX_BI);

   // Parity check; ignored for no-check code and parity-less frames
   always @* begin
      case (bi_par)
         `DSPC_PAR_EVEN: rx_exp = rx_eight ? ^rx_sh_q : ^rx_sh_q[7:1];
         `DSPC_PAR_ODD:  rx_exp = rx_eight ? ~^rx_sh_q : ~^rx_sh_q[7:1];
         `DSPC_PAR_ONE:  rx_exp = 1'b1;
         default:        rx_exp = 1'b0;
      endcase
      rx_bad = rx_haspar && (bi_par != `DSPC_PAR_NONE) && (rx_exp != rx_pbit_q);
   end

   always @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         rx_st_q   <= RX_IDLE;
         rx_cnt_q  <= 4'h0;
         rx_sh_q   <= 8'h00;
         rx_pbit_q <= 1'b0;
         rx_act_q  <= 1'b0;
      end else begin
         case (rx_st_q)
            RX_IDLE: begin
               if (!bi_rxd_i)
                  rx_st_q <= RX_START;
            end
            RX_START: begin
               if (bi_half) begin
                  rx_st_q  <= bi_rxd_i ? RX_IDLE : RX_DATA;
                  rx_cnt_q <= rx_bits;
               end
            end
            RX_DATA: begin
               if (bi_half) begin
                  if (rx_haspar && rx_cnt_q == 4'h1)
                     rx_pbit_q <= bi_rxd_i;
                  else
                     rx_sh_q <= {bi_rxd_i, rx_sh_q[7:1]};
                  rx_cnt_q <= rx_cnt_q - 1'b1;
                  if (rx_cnt_q == 4'h1)
                     rx_st_q <= RX_STOP;
               end
            end
            RX_STOP: begin
               if (bi_half)
                  rx_st_q <= RX_IDLE;
            end
            default: rx_st_q <= RX_IDLE;
         endcase
         rx_act_q <= (rx_st_q != RX_IDLE);
      end
   end

   wire rx_done = (rx_st_q == RX_STOP) && bi_half;
   wire rx_ctrl = (bi_hs == `DSPC_HS_XONOFF)
                  && (rx_byte == `DSPC_CH_XON || rx_byte == `DSPC_CH_XOFF);

   // ----------------------------------------------------------------------
   // Register writes and receive status
   // ----------------------------------------------------------------------
   always @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         cfg_bi_q   <= `DSPC_RST_CFG_BI;
         cfg_uni_q  <= `DSPC_RST_CFG_UNI;
         txb_q      <= 8'h00;
         txb_full_q <= 1'b0;
         txu_q      <= 8'h00;
         txu_full_q <= 1'b0;
         rx_q       <= 8'h00;
         rx_full_q  <= 1'b0;
         rx_ovr_q   <= 1'b0;
         rx_perr_q  <= 1'b0;
         xoff_q     <= 1'b0;
         bad_cfg_q  <= 1'b0;
      end else begin
         if (wr_cfg_bi) begin
            bad_cfg_q <= !bi_ok;
            if (bi_ok)
               cfg_bi_q <= {d0, d1[2:0], d2[1:0], d3[2:0], 4'h0, d4[0]};
         end
         if (wr_cfg_uni) begin
            bad_cfg_q <= !u_ok;
            if (u_ok)
               cfg_uni_q <= {d1, d2[2:0], d3[0], d4[2:0], 3'h0};
         end
         if (wr_i && addr_i == `DSPC_A_TX_BI && !txb_full_q) begin
            txb_q      <= wdata_i[7:0];
            txb_full_q <= 1'b1;
         end else if (bi_go)
            txb_full_q <= 1'b0;
         if (wr_i && addr_i == `DSPC_A_TX_UNI && !txu_full_q) begin
            txu_q      <= wdata_i[7:0];
            txu_full_q <= 1'b1;
         end else if (u_go)
            txu_full_q <= 1'b0;
         if (bi_hs != `DSPC_HS_XONOFF)
            xoff_q <= 1'b0;
         else if (rx_done && rx_byte == `DSPC_CH_XOFF)
            xoff_q <= 1'b1;
         else if (rx_done && rx_byte == `DSPC_CH_XON)
            xoff_q <= 1'b0;
         if (rx_done && !rx_ctrl) begin
            rx_q      <= rx_byte;
            rx_full_q <= 1'b1;
            rx_perr_q <= rx_bad;
            if (rx_full_q && !rd_rx)
               rx_ovr_q <= 1'b1;
         end else if (rd_rx) begin
            rx_full_q <= 1'b0;
            rx_ovr_q  <= 1'b0;
            rx_perr_q <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Read port
   // ----------------------------------------------------------------------
   always @(posedge sys_clk_i) begin
      if (sys_rst_i)
         rdata_o <= 32'h00000000;
      else if (rd_i) begin
         case (addr_i)
            `DSPC_A_CFG_BI:  rdata_o <= {15'h0, cfg_bi_q};
            `DSPC_A_CFG_UNI: rdata_o <= {18'h0, cfg_uni_q};
            `DSPC_A_RX_BI:   rdata_o <= {24'h0, rx_q};
            `DSPC_A_STATUS:  rdata_o <= {22'h0, bad_cfg_q, rx_act_q, xoff_q,
                                         rx_perr_q, rx_ovr_q, rx_full_q,
                                         u_tx_busy, txu_full_q,
                                         bi_tx_busy, txb_full_q};
            default:         rdata_o <= 32'h00000000;
         endcase
      end else
         rdata_o <= 32'h00000000;
   end

   assign bi_rts_o       = !rx_full_q || (bi_hs != `DSPC_HS_MODEM);
   assign bi_rs232_sel_o = bi_if;
endmodule

// File: verif/dspc_top_props.sv
// Checker for the dual serial port top: register strobes and serial lines
// Assumes it is bound to the top module and sees only its ports
`timescale 1ns/1ns
`include "dspc_defs.vh"
module dspc_top_props (
   input wire logic                    sys_clk_i,
   input wire logic                    sys_rst_i,
   input wire logic [`DSPC_ADDR_W-1:0] addr_i,
   input wire logic [31:0]             wdata_i,
   input wire logic                    wr_i,
   input wire logic                    rd_i,
   input wire logic [31:0]             rdata_o,
   input wire logic                    bi_txd_o,
   input wire logic                    bi_rts_o,
   input wire logic                    bi_rs232_sel_o,
   input wire logic                    uni_txd_o,
   input wire logic                    uni_busy_n_i
);
   // ---------------------------------------------------------------
   // Helper state
   // ---------------------------------------------------------------
   logic [3:0] bi_hs_q;
   logic       uni_hs_q;
   logic       bi_go_q;
   logic       uni_go_q;
   logic       bad_bi;
   logic       bad_uni;

   assign bad_bi  = wdata_i > 32'd99999 || wdata_i < 32'd10000 || wdata_i / 10000 == 9
                    || wdata_i / 1000 % 10 > 4 || wdata_i / 100 % 10 > 3
                    || wdata_i / 10 % 10 > 5 || wdata_i % 10 > 1
                    || (wdata_i / 100 % 10 == 1 && wdata_i % 10 == 0);
   assign bad_uni = wdata_i > 32'd9999 || wdata_i < 32'd1000 || wdata_i / 1000 > 7
                    || wdata_i / 100 % 10 > 3 || wdata_i / 10 % 10 > 1 || wdata_i % 10 > 5;

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         bi_hs_q  <= 4'h0;
         uni_hs_q <= 1'b0;
         bi_go_q  <= 1'b0;
         uni_go_q <= 1'b0;
      end else begin
         if (wr_i && addr_i == `DSPC_A_CFG_BI && !bad_bi) begin
            bi_hs_q <= 4'((wdata_i / 100) % 10);
         end
         if (wr_i && addr_i == `DSPC_A_CFG_UNI && !bad_uni) begin
            uni_hs_q <= (wdata_i / 10) % 10 == 1;
         end
         if (!bi_txd_o) begin
            bi_go_q <= 1'b1;
         end
         if (!uni_txd_o) begin
            uni_go_q <= 1'b1;
         end
      end
   end

   // ---------------------------------------------------------------
   // Properties
   // ---------------------------------------------------------------
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (sys_rst_i);

   sequence start_bit_s(l);
      !l [*8];
   endsequence
   sequence bad_wr_s;
      wr_i && addr_i == `DSPC_A_CFG_BI && bad_bi;
   endsequence
   sequence stat_rd_s;
      rd_i && addr_i == `DSPC_A_STATUS;
   endsequence

   reset_lines_a: assert property ($fell(sys_rst_i) |-> bi_txd_o && uni_txd_o && bi_rts_o
      && bi_rs232_sel_o) else $error("lines wrong after reset");
   rdata_idle_a: assert property (!rd_i |=> rdata_o == 32'h0)
      else $error("read data without read");
   cfg_read_a: assert property (rd_i && addr_i == `DSPC_A_CFG_BI |=>
      rdata_o[16:13] inside {[4'h1:4'h8]} && rdata_o[0] == bi_rs232_sel_o)
      else $error("config readback inconsistent");
   sel_source_a: assert property ($changed(bi_rs232_sel_o) |->
      $past(wr_i) && $past(addr_i) == `DSPC_A_CFG_BI) else $error("interface select moved");
   rts_ready_a: assert property (bi_hs_q != 4'h1 |-> bi_rts_o)
      else $error("ready low without modem handshake");
   first_start_a: assert property (wr_i && addr_i == `DSPC_A_TX_BI && !bi_go_q
      && bi_hs_q == 4'h0 |-> ##[1:3] !bi_txd_o) else $error("no start bit");
   bi_start_a: assert property ($fell(bi_txd_o) |-> start_bit_s(bi_txd_o))
      else $error("short start bit");
   uni_start_a: assert property ($fell(uni_txd_o) |-> start_bit_s(uni_txd_o))
      else $error("short start bit on output port");
   busy_hold_a: assert property (uni_hs_q && !uni_busy_n_i && !uni_go_q |=> uni_txd_o)
      else $error("sent while receiver busy");
   bad_cfg_a: assert property (bad_wr_s ##[1:2] stat_rd_s |=> rdata_o[9])
      else $error("bad config not flagged");
endmodule

bind dspc_top dspc_top_props u_props (
   .sys_clk_i      (sys_clk_i),
   .sys_rst_i      (sys_rst_i),
   .addr_i         (addr_i),
   .wdata_i        (wdata_i),
   .wr_i           (wr_i),
   .rd_i           (rd_i),
   .rdata_o        (rdata_o),
   .bi_txd_o       (bi_txd_o),
   .bi_rts_o       (bi_rts_o),
   .bi_rs232_sel_o (bi_rs232_sel_o),
   .uni_txd_o      (uni_txd_o),
   .uni_busy_n_i   (uni_busy_n_i)
);

// File: verif/dspc_far_end.sv
// Far-end model: terminal on the two-way port, busy line of the printer
// Assumes its tasks are called just after a rising clock edge
`timescale 1ns/1ns
module dspc_far_end (
   input  wire logic sys_clk_i,
   input  wire logic line_i,
   output logic      line_o,
   output logic      busy_n_o
);
   initial begin
      line_o   = 1'b1;
      busy_n_o = 1'b1;
   end

   // Wait for the start edge, then sample each bit in its middle
   task automatic grab(input int per, input int n, output logic [31:0] bits);
      bits = 32'h0;
      while (line_i !== 1'b0) @(posedge sys_clk_i);
      repeat (per / 2) @(posedge sys_clk_i);
      for (int i = 0; i < n; i++) begin
         bits[i] = line_i;
         if (i < n - 1) repeat (per) @(posedge sys_clk_i);
      end
   endtask

   // Send a frame LSB first, line idles high afterwards
   task automatic send(input int per, input int n, input logic [31:0] bits);
      for (int i = 0; i < n; i++) begin
         line_o <= bits[i];
         repeat (per) @(posedge sys_clk_i);
      end
      line_o <= 1'b1;
   endtask

   // Low means the printer cannot accept characters
   task automatic hold(input logic v);
      busy_n_o <= v;
   endtask
endmodule

// File: verif/dspc_top_test.sv
// Self-checking bench for the dual serial port top
// Assumes the far-end model drives the receive and busy lines
`timescale 1ns/1ns
`include "dspc_defs.vh"
module dspc_top_test;
   logic                    sys_clk_i;
   logic                    sys_rst_i;
   logic [`DSPC_ADDR_W-1:0] addr_i;
   logic [31:0]             wdata_i;
   logic                    wr_i;
   logic                    rd_i;
   logic                    bi_cts_i;
   wire logic [31:0]        rdata_o;
   wire logic               bi_txd_o;
   wire logic               bi_rxd_i;
   wire logic               bi_rts_o;
   wire logic               bi_rs232_sel_o;
   wire logic               uni_txd_o;
   wire logic               uni_busy_n_i;
   int                      errors;
   int                      n_tests;
   int                      bad_bi[7] = '{91041, 85041, 80441, 80161, 80142, 80140, 612410};
   int                      bad_uni[5] = '{8010, 4410, 4020, 4016, 14010};

   dspc_top DUT (
      .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .bi_txd_o(bi_txd_o),
      .bi_rxd_i(bi_rxd_i), .bi_rts_o(bi_rts_o), .bi_cts_i(bi_cts_i),
      .bi_rs232_sel_o(bi_rs232_sel_o), .uni_txd_o(uni_txd_o), .uni_busy_n_i(uni_busy_n_i)
   );
   dspc_far_end far (
      .sys_clk_i(sys_clk_i), .line_i(bi_txd_o), .line_o(bi_rxd_i), .busy_n_o(uni_busy_n_i)
   );

   // ---------------------------------------------------------------
   // Model and bus tasks
   // ---------------------------------------------------------------
   function automatic logic [31:0] pack_bi(input int b, p, h, f, i);
      return 32'(b << 13 | p << 10 | h << 8 | f << 5 | i);
   endfunction
   function automatic logic [31:0] pack_uni(input int b, p, h, f);
      return 32'(b << 10 | p << 7 | h << 6 | f << 3);
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      addr_i  <= a;
      wdata_i <= d;
      wr_i    <= 1'b1;
      @(posedge sys_clk_i);
      wr_i <= 1'b0;
      @(posedge sys_clk_i);
   endtask
   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      addr_i <= a;
      rd_i   <= 1'b1;
      @(posedge sys_clk_i);
      rd_i <= 1'b0;
      @(posedge sys_clk_i);
      d = rdata_o;
   endtask
   task automatic results();
      if (errors == 0 && n_tests > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   // ---------------------------------------------------------------
   // Clock, timeout, main sequence
   // ---------------------------------------------------------------
   initial begin
      sys_clk_i = 1'b0;
      forever #10 sys_clk_i = ~sys_clk_i;
   end
   initial begin
      repeat (112000) @(posedge sys_clk_i);
      errors++;
      results();
   end
   initial begin
      logic [31:0] d;
      logic [31:0] bits;
      logic [31:0] exp_bi;
      logic [7:0]  r;
      int          b, p, h, f, c;
      sys_rst_i = 1'b1;
      addr_i = '0;
      wdata_i = 32'h0;
      wr_i = 1'b0;
      rd_i = 1'b0;
      bi_cts_i = 1'b1;
      errors = 0;
      n_tests = 0;
      c = $urandom(32'h0111);
      repeat (6) @(posedge sys_clk_i);
      sys_rst_i <= 1'b0;
      @(posedge sys_clk_i);
      chk({bi_txd_o, uni_txd_o, bi_rts_o, bi_rs232_sel_o}, 32'hF);
      rd(`DSPC_A_CFG_BI, d);
      chk(d, pack_bi(8, 0, 0, 1, 1));
      rd(`DSPC_A_CFG_UNI, d);
      chk(d, pack_uni(4, 0, 0, 1));
      for (int i = 0; i < 10; i++) begin
         b = 1 + i % 8;
         p = i % 5;
         h = i % 4;
         f = i % 6;
         c = (h == 1) ? 1 : $urandom % 2;
         exp_bi = pack_bi(b, p, h, f, c);
         wr(`DSPC_A_CFG_BI, 32'(b * 10000 + p * 1000 + h * 100 + f * 10 + c));
         rd(`DSPC_A_CFG_BI, d);
         chk(d, exp_bi);
         chk(bi_rs232_sel_o, c[0]);
      end
      for (int i = 0; i < 7; i++) begin
         wr(`DSPC_A_CFG_UNI, 32'((i + 1) * 1000 + (i % 4) * 100 + (i % 2) * 10 + i % 6));
         rd(`DSPC_A_CFG_UNI, d);
         chk(d, pack_uni(i + 1, i % 4, i % 2, i % 6));
      end
      foreach (bad_bi[i]) begin
         wr(`DSPC_A_CFG_BI, 32'(bad_bi[i]));
         rd(`DSPC_A_STATUS, d);
         chk(d[9], 1'b1);
         rd(`DSPC_A_CFG_BI, d);
         chk(d, exp_bi);
      end
      foreach (bad_uni[i]) begin
         wr(`DSPC_A_CFG_UNI, 32'(bad_uni[i]));
         rd(`DSPC_A_CFG_UNI, d);
         chk(d, pack_uni(7, 2, 0, 0));
      end
      wr(`DSPC_A_CFG_BI, 32'd84041);
      rd(`DSPC_A_STATUS, d);
      chk(d[9], 1'b0);
      r = 8'($urandom);
      fork
         far.grab(5208, 20, bits);
         far.send(5208, 10, {22'h0, 1'b1, ~^r[6:0], r[6:0], 1'b0});
         begin
            wr(`DSPC_A_TX_BI, 32'h5A);
            c = 0;
            d = 32'h1;
            while (d[0] && c < 100) begin
               rd(`DSPC_A_STATUS, d);
               c++;
            end
            wr(`DSPC_A_TX_BI, {24'h0, r});
         end
      join
      chk(bits, {12'h0, 2'b10, r[6:0], 3'b010, 7'h5A, 1'b0});
      rd(`DSPC_A_STATUS, d);
      chk(d[6:4], 3'b001);
      rd(`DSPC_A_RX_BI, d);
      chk(d, {25'h0, r[6:0]});
      rd(`DSPC_A_STATUS, d);
      chk(d[4], 1'b0);
      do
         rd(`DSPC_A_STATUS, d);
      while (d[1]);
      wr(`DSPC_A_CFG_BI, 32'd84141);
      bi_cts_i <= 1'b0;
      wr(`DSPC_A_TX_BI, 32'h33);
      repeat (300) @(posedge sys_clk_i);
      chk(bi_txd_o, 1'b1);
      bi_cts_i <= 1'b1;
      repeat (3) @(posedge sys_clk_i);
      chk(bi_txd_o, 1'b0);
      wr(`DSPC_A_CFG_UNI, 32'd7110);
      far.hold(1'b0);
      wr(`DSPC_A_TX_UNI, 32'hA5);
      c = 0;
      repeat (300) begin
         @(posedge sys_clk_i);
         if (uni_txd_o !== 1'b1) c++;
      end
      chk(c, 0);
      rd(`DSPC_A_STATUS, d);
      chk(d[3] | d[2], 1'b1);
      far.hold(1'b1);
      c = 0;
      while (uni_txd_o === 1'b1 && c < 50) begin
         @(posedge sys_clk_i);
         c++;
      end
      chk(uni_txd_o, 1'b0);
      results();
   end
endmodule
